/* core/ptpa_defines.svh */
`ifndef PTPA_DEFINES_SVH
`define PTPA_DEFINES_SVH
`define PTPA_NS_PER_SEC   32'h3b9aca00
`define PTPA_IDX_LATCH    4'h0
`define PTPA_IDX_SEC_MSB  4'hb
`define PTPA_FMAX_FULL_MHZ 1000
`define PTPA_FMAX_SLOW_MHZ 750
`define PTPA_SUBNS_PER_NS_X1000 256000
`define PTPA_TOD_RST      88'h0
`endif

/* core/ptpa_pkg.sv */
package ptpa_pkg;
  typedef struct packed {
    logic [47:0] sec;
    logic [31:0] ns;
    logic [7:0]  subns;
  } ptpa_tod_t;
  typedef enum logic [2:0] {
    PTPA_SRC_OFF, PTPA_SRC_PPS, PTPA_SRC_SYNC, PTPA_SRC_GPIO,
    PTPA_SRC_TIMER, PTPA_SRC_CSR, PTPA_SRC_IRQ
  } ptpa_src_t;
  typedef struct packed {
    logic        cycle_mode;
    logic [7:0]  ns_inc;
    logic [7:0]  subns_inc;
    logic [15:0] rem_inc;
    logic [15:0] rem_den;
    ptpa_src_t   load_sel;
    ptpa_src_t   latch_sel;
    logic        continuous;
  } ptpa_cfg_t;
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [1:0] ch;
    logic [3:0] idx;
    logic [7:0] data;
  } ptpa_host_t;
endpackage : ptpa_pkg

/* core/ptpa_time_accum.sv */
`timescale 1ns/1ns
`include "ptpa_defines.svh"
module ptpa_time_accum #(
  parameter int NUM_CH = 4
) (
  input  wire logic                                core_clk,     // Accumulator clock
  input  wire logic                                rstn,         // Async reset
  input  wire ptpa_pkg::ptpa_cfg_t [NUM_CH-1:0]    cfg,          // Per-channel setup
  input  wire logic [NUM_CH-1:0]                   arm_load,     // Arm load source
  input  wire logic [NUM_CH-1:0]                   arm_latch,    // Arm latch source
  input  wire ptpa_pkg::ptpa_host_t                host,         // Host byte access
  input  wire logic [NUM_CH-1:0]                   sync_pin,     // External sync pulses
  input  wire logic                                gpio_pin,     // General purpose pin
  input  wire logic                                irq_pin,      // Routed interrupt pin
  input  wire logic                                csr_access,   // Preset register hit
  input  wire logic                                timer_en,     // Global timer run
  input  wire logic [31:0]                         timer_reload, // Timer period, cycles
  output ptpa_pkg::ptpa_tod_t [NUM_CH-1:0]         tod_now,      // Running time
  output ptpa_pkg::ptpa_tod_t [NUM_CH-1:0]         tod_latched,  // Captured time
  output logic [NUM_CH-1:0]                        pps_out,      // Seconds pulse
  output logic [NUM_CH-1:0]                        load_done,    // Load happened
  output logic [NUM_CH-1:0]                        latch_done,   // Latch happened
  output logic [NUM_CH-1:0]                        rate_limited, // Counting cycles, by mode or fallback
  output logic                                     host_rd_vld,  // Read data valid
  output logic [7:0]                               host_rd_data  // Read data byte
);
  import ptpa_pkg::*;

  localparam int NPIN = NUM_CH + 2;

  function automatic logic src_hit(input ptpa_src_t sel, input logic [6:0] ev);
    src_hit = ev[sel];
  endfunction : src_hit

  // Only these sources may overwrite the time
  function automatic logic may_load(input ptpa_src_t sel);
    may_load = (sel == PTPA_SRC_SYNC) || (sel == PTPA_SRC_TIMER) ||
               (sel == PTPA_SRC_CSR) || (sel == PTPA_SRC_IRQ);
  endfunction : may_load

  // Pin synchronisers; a level counts once stages two and three agree
  logic [NPIN-1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_lvl_q;
  wire  [NPIN-1:0] pin_raw   = {irq_pin, gpio_pin, sync_pin};
  wire  [NPIN-1:0] pin_agree = ~(pin_s2_q ^ pin_s3_q);
  wire  [NPIN-1:0] pin_rise  = pin_agree & pin_s2_q & ~pin_lvl_q;
  wire  [NPIN-1:0] pin_lvl_d = (pin_agree & pin_s2_q) | (~pin_agree & pin_lvl_q);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin_s1_q  <= '0;
      pin_s2_q  <= '0;
      pin_s3_q  <= '0;
      pin_lvl_q <= '0;
    end else begin
      pin_s1_q  <= pin_raw;
      pin_s2_q  <= pin_s1_q;
      pin_s3_q  <= pin_s2_q;
      pin_lvl_q <= pin_lvl_d;
    end
  end

  wire gpio_edge = pin_rise[NUM_CH];
  wire irq_edge  = pin_rise[NUM_CH+1];

  logic [31:0] tmr_q;
  wire         tmr_exp = timer_en && (tmr_q <= 32'h1);
  wire  [31:0] tmr_d   = !timer_en ? timer_reload :
                         tmr_exp ? timer_reload : tmr_q - 32'h1;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) tmr_q <= '0;
    else       tmr_q <= tmr_d;
  end

  // Highest accepted rate expressed as least period in 1/256 ns, rounded up
  localparam logic [15:0] MINP_FULL = 16'((`PTPA_SUBNS_PER_NS_X1000 +
    `PTPA_FMAX_FULL_MHZ - 1) / `PTPA_FMAX_FULL_MHZ);
  localparam logic [15:0] MINP_SLOW = 16'((`PTPA_SUBNS_PER_NS_X1000 +
    `PTPA_FMAX_SLOW_MHZ - 1) / `PTPA_FMAX_SLOW_MHZ);

  wire host_rd = host.valid && !host.write;
  wire host_wr = host.valid && host.write;
  logic [7:0] rd_byte [NUM_CH];

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    ptpa_tod_t   tod_q, shadow_q, latch_q;
    logic [15:0] rem_q;
    logic        load_arm_q, latch_arm_q, pps_q, ld_q, lt_q;

    wire sel_ch = host.ch == 2'(c);
    // upper channels run at a lower ceiling
    wire [15:0] minp   = (c >= 2) ? MINP_SLOW : MINP_FULL;
    wire [15:0] period = {cfg[c].ns_inc, cfg[c].subns_inc};
    // unsupported rate falls back to cycle counting
    wire        cyc    = cfg[c].cycle_mode || (period < minp);

    // flexible modulus remainder feeds one extra sub-ns step
    wire [16:0] rem_sum  = {1'b0, rem_q} + {1'b0, cfg[c].rem_inc};
    wire        rem_wrap = (cfg[c].rem_den != 16'h0) && (rem_sum >= {1'b0, cfg[c].rem_den});
    wire [15:0] rem_nx   = rem_wrap ? 16'(rem_sum - {1'b0, cfg[c].rem_den}) : rem_sum[15:0];

    // add period: fraction then ns with carry
    wire [8:0]  sub_sum = {1'b0, tod_q.subns} + {1'b0, cfg[c].subns_inc} + {8'h0, rem_wrap};
    wire [32:0] ns_sum  = {1'b0, tod_q.ns} + {25'h0, cfg[c].ns_inc} + {32'h0, sub_sum[8]};
    wire        ns_roll = ns_sum >= {1'b0, `PTPA_NS_PER_SEC};
    wire [31:0] ns_frac = ns_roll ? 32'(ns_sum - {1'b0, `PTPA_NS_PER_SEC}) : ns_sum[31:0];

    // plain count, full 32-bit ns wrap into seconds
    wire [32:0] cyc_sum = {1'b0, tod_q.ns} + 33'h1;
    wire        sec_up  = cyc ? cyc_sum[32] : ns_roll;

    wire ptpa_tod_t tod_step = '{
      sec:   sec_up ? tod_q.sec + 48'h1 : tod_q.sec,
      ns:    cyc ? cyc_sum[31:0] : ns_frac,
      subns: cyc ? 8'h0 : sub_sum[7:0]
    };

    wire [6:0] ev = {irq_edge, csr_access, tmr_exp, gpio_edge,
                     pin_rise[c], pps_q, 1'b0};

    wire host_ld = host_wr && sel_ch && (host.idx == `PTPA_IDX_SEC_MSB);
    wire host_lt = host_rd && sel_ch && (host.idx == `PTPA_IDX_LATCH);
    wire arm_ld  = load_arm_q && may_load(cfg[c].load_sel) && src_hit(cfg[c].load_sel, ev);
    wire arm_lt  = latch_arm_q && src_hit(cfg[c].latch_sel, ev);
    wire do_ld   = host_ld || arm_ld;
    wire do_lt   = host_lt || arm_lt;

    wire ws = host_wr && sel_ch && (host.idx != `PTPA_IDX_LATCH) && (host.idx <= `PTPA_IDX_SEC_MSB);
    wire [6:0] wbit = 7'({host.idx - 4'h1, 3'h0});
    ptpa_tod_t shadow_d;
    always_comb begin
      shadow_d = shadow_q;
      // eleven-byte value, byte one is sub-ns
      if (ws) shadow_d[wbit +: 8] = host.data;
    end

    // Arm requests win over the clear from a firing source
    wire load_arm_d  = arm_load[c] || (load_arm_q && !(arm_ld && !cfg[c].continuous));
    wire latch_arm_d = arm_latch[c] || (latch_arm_q && !(arm_lt && !cfg[c].continuous));

    // The new value written just now must reach the accumulator in the same load
    wire ptpa_tod_t tod_d = do_ld ? shadow_d : tod_step;

    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        tod_q       <= `PTPA_TOD_RST;
        shadow_q    <= `PTPA_TOD_RST;
        latch_q     <= `PTPA_TOD_RST;
        rem_q       <= '0;
        load_arm_q  <= 1'b0;
        latch_arm_q <= 1'b0;
        pps_q       <= 1'b0;
        ld_q        <= 1'b0;
        lt_q        <= 1'b0;
      end else begin
        tod_q       <= tod_d;
        shadow_q    <= shadow_d;
        rem_q       <= (do_ld || cyc) ? 16'h0 : rem_nx;
        if (do_lt) latch_q <= tod_q;
        load_arm_q  <= load_arm_d;
        latch_arm_q <= latch_arm_d;
        // seconds pulse marks each counted second edge
        pps_q       <= sec_up && !do_ld;
        ld_q        <= do_ld;
        lt_q        <= do_lt;
      end
    end

    wire [3:0] ri = (host.idx == `PTPA_IDX_LATCH) ? 4'h0 : host.idx - 4'h1;
    assign rd_byte[c]      = (host.idx > `PTPA_IDX_SEC_MSB) ? 8'h0 : latch_q[{ri, 3'h0} +: 8];
    assign tod_now[c]      = tod_q;
    assign tod_latched[c]  = latch_q;
    assign pps_out[c]      = pps_q;
    assign load_done[c]    = ld_q;
    assign latch_done[c]   = lt_q;
    assign rate_limited[c] = cyc;
  end

  // Byte mux reads latch before this cycle's capture; idx 0 returns byte one
  logic       rd_vld_q;
  logic [7:0] rd_data_q;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rd_vld_q  <= 1'b0;
      rd_data_q <= 8'h0;
    end else begin
      rd_vld_q  <= host_rd;
      rd_data_q <= host_rd ? rd_byte[host.ch] : rd_data_q;
    end
  end
  assign host_rd_vld  = rd_vld_q;
  assign host_rd_data = rd_data_q;

endmodule : ptpa_time_accum

/* sim/ptpa_host_model.sv */
`timescale 1ns/1ns
module ptpa_host_model (
  input  wire logic           core_clk,    // Clock
  output ptpa_pkg::ptpa_host_t host,       // Byte access
  input  wire logic [7:0]     host_rd_data // Read byte
);
  import ptpa_pkg::*;
  initial host = '0;
  task acc(input logic w, input logic [1:0] c, input logic [3:0] i, input logic [7:0] d);
    host <= '{valid: 1'b1, write: w, ch: c, idx: i, data: d};
    @(posedge core_clk);
  endtask : acc
  task idle();
    host <= '0;
    @(posedge core_clk);
  endtask : idle
  task wr_time(input logic [1:0] c, input ptpa_tod_t t);
    for (int i = 1; i <= 11; i++) acc(1'b1, c, i[3:0], t[8*(i-1) +: 8]);
  endtask : wr_time
  task rd_time(input logic [1:0] c, output ptpa_tod_t t);
    acc(1'b0, c, 4'h0, 8'h00);
    for (int i = 1; i <= 12; i++) begin
      acc(1'b0, c, i[3:0], 8'h00);
      // Answer lags one access behind
      if (i >= 2) t[8*(i-2) +: 8] = host_rd_data;
    end
  endtask : rd_time
endmodule : ptpa_host_model

/* sim/ptpa_time_accum_monitor.sv */
`timescale 1ns/1ns
module ptpa_time_accum_monitor #(
  parameter int NUM_CH = 4
) (
  input wire logic                             core_clk,     // Clock
  input wire logic                             rstn,         // Reset
  input wire ptpa_pkg::ptpa_cfg_t [NUM_CH-1:0] cfg,          // Setup
  input wire ptpa_pkg::ptpa_host_t             host,         // Host access
  input wire ptpa_pkg::ptpa_tod_t [NUM_CH-1:0] tod_now,      // Running time
  input wire ptpa_pkg::ptpa_tod_t [NUM_CH-1:0] tod_latched,  // Captured time
  input wire logic [NUM_CH-1:0]                pps_out,      // Seconds pulse
  input wire logic [NUM_CH-1:0]                load_done,    // Load pulse
  input wire logic [NUM_CH-1:0]                latch_done,   // Latch pulse
  input wire logic [NUM_CH-1:0]                rate_limited, // Count mode
  input wire logic                             host_rd_vld   // Read valid
);
  import ptpa_pkg::*;
  wire ld_msb = host.valid && host.write && host.idx == 4'hb && host.ch == 2'h0;
  wire rd_pre = host.valid && !host.write && host.idx == 4'h0 && host.ch == 2'h0;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  AST_LOAD_MSB: assert property (ld_msb |=> load_done[0] && tod_now[0].sec[47:40] == $past(host.data))
    else $error("no load after top seconds byte");
  AST_LATCH_PRE: assert property (rd_pre |=> latch_done[0] && tod_latched[0] == $past(tod_now[0]))
    else $error("no latch after leading read");
  AST_RD_ANSWER: assert property (host.valid && !host.write |=> host_rd_vld)
    else $error("read not answered");
  AST_NS_RANGE: assert property (!rate_limited[0] && tod_now[0].ns < 32'h3b9aca00 |=> load_done[0] || tod_now[0].ns < 32'h3b9aca00)
    else $error("nanoseconds past one second");
  AST_CARRY: assert property (!load_done[0] && tod_now[0].ns < $past(tod_now[0].ns) |-> tod_now[0].sec == $past(tod_now[0].sec) + 48'h1)
    else $error("wrap without seconds carry");
  AST_PPS: assert property (!load_done[0] && tod_now[0].sec == $past(tod_now[0].sec) + 48'h1 |-> pps_out[0])
    else $error("seconds pulse missing");
  AST_CYCLE: assert property (rate_limited[0] |=> load_done[0] || tod_now[0].ns == $past(tod_now[0].ns) + 32'h1)
    else $error("count mode step not one");
  AST_NO_PIN_LOAD: assert property (cfg[0].load_sel inside {PTPA_SRC_OFF, PTPA_SRC_PPS, PTPA_SRC_GPIO} && !ld_msb |=> !load_done[0])
    else $error("load from latch-only source");
  AST_RESET: assert property (disable iff (1'b0) !rstn |-> tod_now[0] == '0 && load_done == '0 && latch_done == '0 && pps_out == '0)
    else $error("outputs not clear in reset");
  cover property (pps_out[0]);
  cover property (latch_done[0]);
  cover property (rate_limited[0]);
endmodule : ptpa_time_accum_monitor
bind ptpa_time_accum ptpa_time_accum_monitor #(.NUM_CH(NUM_CH)) u_mon (
  .core_clk(core_clk), .rstn(rstn), .cfg(cfg), .host(host), .tod_now(tod_now),
  .tod_latched(tod_latched), .pps_out(pps_out), .load_done(load_done),
  .latch_done(latch_done), .rate_limited(rate_limited), .host_rd_vld(host_rd_vld));

/* sim/test_ptp_time_accumulator.sv */
`timescale 1ns/1ns
module test_ptp_time_accumulator;
  import ptpa_pkg::*;
  logic            core_clk, rstn, gpio_pin, irq_pin, csr_access, timer_en, host_rd_vld;
  logic [3:0]      arm_load, arm_latch, sync_pin, pps_out, load_done, latch_done, rate_limited;
  logic [31:0]     timer_reload;
  logic [7:0]      host_rd_data;
  ptpa_cfg_t [3:0] cfg;
  ptpa_tod_t [3:0] tod_now, tod_latched;
  ptpa_host_t      host;
  ptpa_tod_t       got;
  int              failures, n_checks, cyc;
  ptpa_time_accum #(.NUM_CH(4)) DUT (
    .core_clk(core_clk), .rstn(rstn), .cfg(cfg), .arm_load(arm_load), .arm_latch(arm_latch),
    .host(host), .sync_pin(sync_pin), .gpio_pin(gpio_pin), .irq_pin(irq_pin),
    .csr_access(csr_access), .timer_en(timer_en), .timer_reload(timer_reload),
    .tod_now(tod_now), .tod_latched(tod_latched), .pps_out(pps_out), .load_done(load_done),
    .latch_done(latch_done), .rate_limited(rate_limited), .host_rd_vld(host_rd_vld),
    .host_rd_data(host_rd_data));
  ptpa_host_model HOST (.core_clk(core_clk), .host(host), .host_rd_data(host_rd_data));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      finish_test();
    end
  end
  task check(input string nm, input logic [87:0] got_v, input logic [87:0] exp_v);
    n_checks++;
    if (got_v !== exp_v) begin
      failures++;
      $display("wrong value %s: expected %h seen %h", nm, exp_v, got_v);
    end
  endtask : check
  task finish_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  task t_reset();
    repeat (8) @(posedge core_clk);
    for (int c = 0; c < 4; c++) check("reset time", tod_now[c], '0);
    rstn <= 1'b1;
    @(posedge core_clk);
  endtask : t_reset
  task t_readback();
    for (int c = 0; c < 4; c++) begin
      HOST.wr_time(c[1:0], {48'(c + 1), 32'h3b9ac9ff, 8'ha5});
      HOST.rd_time(c[1:0], got);
      HOST.idle();
      check("readback", got, {48'(c + 1), 32'h3b9ac9ff, 8'ha5});
    end
  endtask : t_readback
  task t_timed(input ptpa_tod_t t, input int n);
    HOST.wr_time(2'h0, t);
    HOST.idle();
    repeat (n - 1) @(posedge core_clk);
    HOST.rd_time(2'h0, got);
    HOST.idle();
  endtask : t_timed
  task t_rate();
    for (int c = 0; c < 4; c++) cfg[c].subns_inc <= 8'h40;
    @(posedge core_clk);
    check("rate limit", 88'(rate_limited), 88'h0c);
    for (int c = 0; c < 4; c++) cfg[c].subns_inc <= 8'h80;
  endtask : t_rate
  task t_period();
    cfg[0].rem_inc <= 16'h1;
    cfg[0].rem_den <= 16'h2;
    t_timed({48'h5, 32'h3b9ac9fe, 8'h00}, 4);
    // Four 1.5 ns steps plus two modulus carries
    check("period", got, {48'h6, 32'h4, 8'h02});
    cfg[0].rem_den <= 16'h0;
  endtask : t_period
  task t_cycle();
    cfg[0].cycle_mode <= 1'b1;
    t_timed({48'h7, 32'hfffffffe, 8'h00}, 3);
    check("cycle count", got, {48'h8, 32'h1, 8'h00});
    cfg[0].cycle_mode <= 1'b0;
  endtask : t_cycle
  task t_trig(input ptpa_src_t s, input logic ld);
    logic fired;
    fired = 1'b0;
    cfg[0].load_sel <= ld ? s : PTPA_SRC_OFF;
    cfg[0].latch_sel <= ld ? PTPA_SRC_OFF : s;
    // Near a wrap so the seconds pulse falls in the window
    HOST.wr_time(2'h0, {48'h9, 32'h3b9ac9e0, 8'h00});
    HOST.idle();
    arm_load[0] <= ld;
    arm_latch[0] <= !ld;
    @(posedge core_clk);
    {arm_load, arm_latch} <= '0;
    sync_pin[0] <= s == PTPA_SRC_SYNC;
    gpio_pin <= s == PTPA_SRC_GPIO;
    irq_pin <= s == PTPA_SRC_IRQ;
    csr_access <= s == PTPA_SRC_CSR;
    timer_en <= s == PTPA_SRC_TIMER;
    repeat (40) begin
      @(posedge core_clk);
      if ((ld ? load_done[0] : latch_done[0]) === 1'b1) fired = 1'b1;
    end
    {sync_pin, gpio_pin, irq_pin, csr_access, timer_en} <= '0;
    check("trigger", 88'(fired), 88'(s != PTPA_SRC_OFF && !(ld && (s == PTPA_SRC_PPS || s == PTPA_SRC_GPIO))));
  endtask : t_trig
  initial begin
    rstn = 1'b0;
    {arm_load, arm_latch, sync_pin, gpio_pin, irq_pin, csr_access, timer_en} = '0;
    timer_reload = 32'h5;
    failures = 0;
    n_checks = 0;
    cyc = 0;
    for (int c = 0; c < 4; c++) cfg[c] = '{1'b0, 8'h01, 8'h80, 16'h0, 16'h0, PTPA_SRC_OFF, PTPA_SRC_OFF, 1'b0};
    t_reset();
    t_readback();
    t_rate();
    t_period();
    t_cycle();
    for (int l = 0; l < 2; l++) for (int s = 0; s < 7; s++) t_trig(ptpa_src_t'(s), l[0]);
    finish_test();
  end
endmodule : test_ptp_time_accumulator
